//--- rtl/mrau_pkg.sv
// Package of address map, memory type codes and barrier codes for the region attribute unit.
`default_nettype none
package mrau_pkg;
	// Region boundaries of the fixed 4GB address map.
	localparam logic [31:0] SRAM_END    = 32'h3fff_ffff;  // Last code or data RAM address.
	localparam logic [31:0] EXTRAM_BASE = 32'h6000_0000;  // First external RAM address.
	localparam logic [31:0] EXTDEV_BASE = 32'ha000_0000;  // First external device address.
	localparam logic [31:0] PRIV_BASE   = 32'he000_0000;  // First private peripheral address.
	localparam logic [31:0] PRIV_END    = 32'he00f_ffff;  // Last private peripheral address.
	// Window inside the private peripheral region kept for the core's own registers.
	localparam logic [31:0] CORE_BASE   = 32'he000_e000;
	localparam logic [31:0] CORE_END    = 32'he000_efff;
	// Memory type codes, also used as ordering class of an access.
	localparam logic [1:0]  MT_NORMAL   = 2'h0;
	localparam logic [1:0]  MT_DEV_NS   = 2'h1;
	localparam logic [1:0]  MT_DEV_SH   = 2'h2;
	localparam logic [1:0]  MT_STRONG   = 2'h3;
	localparam int          MT_NUM      = 4;
	// Access size code of a full word.
	localparam logic [1:0]  SIZE_WORD   = 2'h2;
	// Barrier kind codes.
	localparam logic [1:0]  BAR_DATA_MEM   = 2'h0;  // Data memory barrier.
	localparam logic [1:0]  BAR_DATA_SYNC  = 2'h1;  // Data sync barrier.
	localparam logic [1:0]  BAR_INSTR_SYNC = 2'h2;  // Instruction sync barrier.
	// Fixed priority of the fault exception.
	localparam logic signed [2:0] FAULT_PRIO = -3'sh1;
	// Reset values.
	localparam logic [31:0] ADDR_RST    = 32'h0000_0000;
	// Barrier sequencer states.
	typedef enum logic {mrau_st_idle, mrau_st_drain} mrau_state_e;
endpackage
`default_nettype wire

//--- rtl/mrau_unit.sv
// Region classifier, access ordering gate and barrier sequencer of the core memory path.
`default_nettype none
module mrau_unit #(
	parameter int CNT_W = 4  // Width of each outstanding transaction counter.
) (
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic              req_valid,
	input  wire logic [31:0]       req_addr,
	input  wire logic              req_write,
	input  wire logic [1:0]        req_size,
	input  wire logic              req_fetch,
	input  wire logic              req_shareable,
	output var  logic              req_ack_reg,
	output var  logic              req_fault_reg,
	input  wire logic              bar_valid,
	input  wire logic [1:0]        bar_kind,
	output var  logic              bar_ack_reg,
	output var  logic              exec_hold_reg,
	output var  logic              refetch_reg,
	output var  logic              bus_valid_reg,
	input  wire logic              bus_ready,
	output var  logic [31:0]       bus_addr_reg,
	output var  logic              bus_write_reg,
	output var  logic [1:0]        bus_size_reg,
	output var  logic              bus_fetch_reg,
	output var  logic [1:0]        bus_type_reg,
	output var  logic              bus_buf_reg,
	output var  logic              bus_core_reg,
	input  wire logic              bus_done,
	input  wire logic [1:0]        bus_done_type,
	output var  logic              fault_exception_reg,
	output var  logic signed [2:0] fault_prio_reg
);
	// Base memory type of an address; Device comes back as the non-shareable code.
	function automatic logic [1:0] mem_type(input logic [31:0] a);
		if (a <= mrau_pkg::SRAM_END) begin
			mem_type = mrau_pkg::MT_NORMAL;
		end else if (a < mrau_pkg::EXTRAM_BASE) begin
			mem_type = mrau_pkg::MT_DEV_NS;
		end else if (a < mrau_pkg::EXTDEV_BASE) begin
			mem_type = mrau_pkg::MT_NORMAL;
		end else if (a < mrau_pkg::PRIV_BASE) begin
			mem_type = mrau_pkg::MT_DEV_NS;
		end else if (a <= mrau_pkg::PRIV_END) begin
			mem_type = mrau_pkg::MT_STRONG;
		end else begin
			mem_type = mrau_pkg::MT_DEV_NS;
		end
	endfunction

	// Only Normal regions may hold programs, so everything else is execute-never.
	function automatic logic is_exec_never(input logic [31:0] a);
		is_exec_never = (mem_type(a) != mrau_pkg::MT_NORMAL);
	endfunction

	// Private peripheral region membership.
	function automatic logic in_priv_region(input logic [31:0] a);
		in_priv_region = (a >= mrau_pkg::PRIV_BASE) && (a <= mrau_pkg::PRIV_END);
	endfunction

	mrau_pkg::mrau_state_e st_reg, st_next;          // Barrier sequencer state.
	logic [1:0]            kind_reg, kind_next;      // Kind of the barrier being drained.
	logic [CNT_W-1:0]      cnt_reg [mrau_pkg::MT_NUM];  // Outstanding accesses per class.
	logic [CNT_W-1:0]      cnt_next [mrau_pkg::MT_NUM];
	logic                  req_ack_next;
	logic                  req_fault_next;
	logic                  bar_ack_next;
	logic                  exec_hold_next;
	logic                  refetch_next;
	logic                  bus_valid_next;
	logic [31:0]           bus_addr_next;
	logic                  bus_write_next;
	logic [1:0]            bus_size_next;
	logic                  bus_fetch_next;
	logic [1:0]            bus_type_next;
	logic                  bus_buf_next;
	logic                  bus_core_next;
	logic                  fault_next;
	logic [1:0]            req_cls;     // Ordering class of the presented access.
	logic                  req_bad;     // Presented access must fault.
	logic                  hazard;      // Presented access must wait for older ones.
	logic                  all_clear;   // Nothing outstanding or waiting on the bus.
	logic                  take;        // Presented access is taken this cycle.
	logic                  issue_hs;    // Bus accepts the held access this cycle.

	// Decode, ordering gate, counters and barrier sequencing in one pass.
	always_comb begin
		// Attributes come straight from the address so no decision costs a cycle.
		req_cls = mem_type(req_addr);
		if (req_cls == mrau_pkg::MT_DEV_NS && req_shareable) begin
			req_cls = mrau_pkg::MT_DEV_SH;
		end
		req_bad = (req_fetch && is_exec_never(req_addr))
			|| (in_priv_region(req_addr) && req_size != mrau_pkg::SIZE_WORD);
		all_clear = !bus_valid_reg;
		for (int i = 0; i < mrau_pkg::MT_NUM; i++) begin
			all_clear = all_clear && (cnt_reg[i] == '0);
		end
		// Each class waits only on the older classes it must stay behind.
		case (req_cls)
			mrau_pkg::MT_NORMAL: begin
				// Normal may pass anything except a strongly-ordered access.
				hazard = (cnt_reg[mrau_pkg::MT_STRONG] != '0);
			end
			mrau_pkg::MT_DEV_NS: begin
				hazard = (cnt_reg[mrau_pkg::MT_DEV_NS] != '0)
					|| (cnt_reg[mrau_pkg::MT_STRONG] != '0);
			end
			mrau_pkg::MT_DEV_SH: begin
				hazard = (cnt_reg[mrau_pkg::MT_DEV_SH] != '0)
					|| (cnt_reg[mrau_pkg::MT_STRONG] != '0);
			end
			default: begin
				hazard = !all_clear;
			end
		endcase
		// A full counter also stalls, trading a little throughput for no overflow.
		if (&cnt_reg[req_cls]) begin
			hazard = 1'b1;
		end
		issue_hs = bus_valid_reg && bus_ready;
		take = req_valid && !req_ack_reg && !bus_valid_reg
			&& (st_reg == mrau_pkg::mrau_st_idle) && (req_bad || !hazard);
		// Defaults hold the bus stage and drop every pulse.
		req_ack_next   = take;
		req_fault_next = take && req_bad;
		fault_next     = take && req_bad;
		bus_valid_next = bus_valid_reg && !bus_ready;
		bus_addr_next  = bus_addr_reg;
		bus_write_next = bus_write_reg;
		bus_size_next  = bus_size_reg;
		bus_fetch_next = bus_fetch_reg;
		bus_type_next  = bus_type_reg;
		bus_buf_next   = bus_buf_reg;
		bus_core_next  = bus_core_reg;
		if (take && !req_bad) begin
			// A faulting access never reaches the bus.
			bus_valid_next = 1'b1;
			bus_addr_next  = req_addr;
			bus_write_next = req_write;
			bus_size_next  = req_size;
			bus_fetch_next = req_fetch;
			bus_type_next  = req_cls;
			// Only strongly-ordered writes must go straight through to the slave.
			bus_buf_next   = req_write && (req_cls != mrau_pkg::MT_STRONG);
			bus_core_next  = (req_addr >= mrau_pkg::CORE_BASE)
				&& (req_addr <= mrau_pkg::CORE_END);
		end
		// Counters rise on acceptance and fall on completion of the given class.
		for (int i = 0; i < mrau_pkg::MT_NUM; i++) begin
			cnt_next[i] = cnt_reg[i];
			if (issue_hs && bus_type_reg == i[1:0]) begin
				cnt_next[i] = cnt_next[i] + 1'b1;
			end
			if (bus_done && bus_done_type == i[1:0] && cnt_reg[i] != '0) begin
				cnt_next[i] = cnt_next[i] - 1'b1;
			end
		end
		// Barrier sequencer.
		st_next      = st_reg;
		kind_next    = kind_reg;
		bar_ack_next = 1'b0;
		refetch_next = 1'b0;
		case (st_reg)
			mrau_pkg::mrau_st_idle: begin
				// A barrier is only taken while no access is half issued.
				if (bar_valid && !bar_ack_reg && !take && !req_ack_reg) begin
					st_next   = mrau_pkg::mrau_st_drain;
					kind_next = bar_kind;
				end
			end
			mrau_pkg::mrau_st_drain: begin
				// Every kind drains; the instruction barrier also refetches.
				if (all_clear) begin
					st_next      = mrau_pkg::mrau_st_idle;
					bar_ack_next = 1'b1;
					refetch_next = (kind_reg == mrau_pkg::BAR_INSTR_SYNC);
				end
			end
			default: begin
				st_next = mrau_pkg::mrau_st_idle;
			end
		endcase
		// Later instructions stay held while a data sync barrier drains.
		exec_hold_next = (st_next == mrau_pkg::mrau_st_drain)
			&& (kind_next == mrau_pkg::BAR_DATA_SYNC);
	end

	// State registers; all take constants under reset.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_reg              <= mrau_pkg::mrau_st_idle;
			kind_reg            <= mrau_pkg::BAR_DATA_MEM;
			for (int i = 0; i < mrau_pkg::MT_NUM; i++) begin
				cnt_reg[i] <= '0;
			end
			req_ack_reg         <= 1'b0;
			req_fault_reg       <= 1'b0;
			bar_ack_reg         <= 1'b0;
			exec_hold_reg       <= 1'b0;
			refetch_reg         <= 1'b0;
			bus_valid_reg       <= 1'b0;
			bus_addr_reg        <= mrau_pkg::ADDR_RST;
			bus_write_reg       <= 1'b0;
			bus_size_reg        <= mrau_pkg::SIZE_WORD;
			bus_fetch_reg       <= 1'b0;
			bus_type_reg        <= mrau_pkg::MT_NORMAL;
			bus_buf_reg         <= 1'b0;
			bus_core_reg        <= 1'b0;
			fault_exception_reg <= 1'b0;
			fault_prio_reg      <= mrau_pkg::FAULT_PRIO;
		end else begin
			st_reg              <= st_next;
			kind_reg            <= kind_next;
			for (int i = 0; i < mrau_pkg::MT_NUM; i++) begin
				cnt_reg[i] <= cnt_next[i];
			end
			req_ack_reg         <= req_ack_next;
			req_fault_reg       <= req_fault_next;
			bar_ack_reg         <= bar_ack_next;
			exec_hold_reg       <= exec_hold_next;
			refetch_reg         <= refetch_next;
			bus_valid_reg       <= bus_valid_next;
			bus_addr_reg        <= bus_addr_next;
			bus_write_reg       <= bus_write_next;
			bus_size_reg        <= bus_size_next;
			bus_fetch_reg       <= bus_fetch_next;
			bus_type_reg        <= bus_type_next;
			bus_buf_reg         <= bus_buf_next;
			bus_core_reg        <= bus_core_next;
			fault_exception_reg <= fault_next;
			fault_prio_reg      <= mrau_pkg::FAULT_PRIO;
		end
	end

	// Helper levels read only by the checks below.
	logic ns_clear;
	assign ns_clear = (cnt_reg[mrau_pkg::MT_DEV_NS] == '0)
		&& (cnt_reg[mrau_pkg::MT_STRONG] == '0);

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// A fetch from an execute-never address faults and stays off the bus.
	a_never_fetch_fault: assert property (take && req_fetch && is_exec_never(req_addr)
		|=> fault_exception_reg && req_fault_reg && !bus_valid_reg)
		else $error("execute-never fetch did not fault");
	// No fetch to an execute-never address is ever issued.
	a_never_fetch_out: assert property (bus_valid_reg && bus_fetch_reg
		|-> !is_exec_never(bus_addr_reg)) else $error("execute-never fetch issued");
	// Code and data RAM accesses leave typed Normal.
	a_low_normal: assert property (bus_valid_reg && bus_addr_reg <= mrau_pkg::SRAM_END
		|-> bus_type_reg == mrau_pkg::MT_NORMAL) else $error("low region not normal");
	// Private region accesses are whole words and strongly ordered.
	a_priv_word_only: assert property (bus_valid_reg && in_priv_region(bus_addr_reg)
		|-> bus_size_reg == mrau_pkg::SIZE_WORD && bus_type_reg == mrau_pkg::MT_STRONG)
		else $error("bad private region access");
	// A strongly-ordered access starts only with nothing outstanding.
	a_strong_alone: assert property ($rose(bus_valid_reg)
		&& bus_type_reg == mrau_pkg::MT_STRONG |-> $past(all_clear))
		else $error("strong access overtook");
	// A non-shareable device access waits for older peers.
	a_dev_ns_order: assert property ($rose(bus_valid_reg)
		&& bus_type_reg == mrau_pkg::MT_DEV_NS |-> $past(ns_clear))
		else $error("device order broken");
	// Strongly-ordered writes are never bufferable.
	a_strong_unbuf: assert property (bus_valid_reg && bus_type_reg == mrau_pkg::MT_STRONG
		|-> !bus_buf_reg) else $error("strong write buffered");
	// A barrier is acknowledged only after a fully drained cycle.
	a_barrier_drain: assert property (bar_ack_reg |-> $past(all_clear)
		&& !bus_valid_reg) else $error("barrier ack before drain");
	// A data sync barrier holds execution for its whole drain.
	a_sync_hold: assert property (st_reg == mrau_pkg::mrau_st_drain
		&& kind_reg == mrau_pkg::BAR_DATA_SYNC |-> exec_hold_reg)
		else $error("sync barrier hold missing");
	// Refetch comes with the acknowledge of an instruction barrier only.
	a_instr_refetch: assert property (bar_ack_reg
		|-> refetch_reg == (kind_reg == mrau_pkg::BAR_INSTR_SYNC)) else $error("refetch wrong");

	c_strong_issue: cover property ($rose(bus_valid_reg) && bus_type_reg == mrau_pkg::MT_STRONG);
	c_xn_fault: cover property (fault_exception_reg);
	c_sync_done: cover property (bar_ack_reg && kind_reg == mrau_pkg::BAR_DATA_SYNC);
	c_normal_overlap: cover property (issue_hs && bus_type_reg == mrau_pkg::MT_NORMAL
		&& cnt_reg[mrau_pkg::MT_NORMAL] != '0);
endmodule
`default_nettype wire

//--- dv/mrau_mem_model.sv
// Behavioural memory system on the far side of the region attribute unit.
`default_nettype none
module mrau_mem_model (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       slow,
	input  wire logic       bus_valid_reg,
	input  wire logic [1:0] bus_type_reg,
	output var  logic       bus_ready,
	output var  logic       bus_done,
	output var  logic [1:0] bus_done_type,
	output var  logic [3:0] busy_cls
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [1:0] pend [$];  // Classes of accepted accesses not yet completed.
	// Quiet outputs from time zero.
	initial begin
		bus_ready = 1'b0;
		bus_done = 1'b0;
		bus_done_type = 2'h0;
		busy_cls = 4'h0;
	end
	// Accepts at the edge, then may complete one random pending access, possibly out of order.
	// A slow memory stalls acceptance and completes rarely, which keeps counters loaded.
	always @(posedge clk) begin : serve
		logic       acc;
		logic [1:0] ty;
		int         i;
		acc = bus_valid_reg && bus_ready;
		ty = bus_type_reg;
		#1;
		bus_done = 1'b0;
		// The class lines are not held after a completion, so they toggle.
		bus_done_type = ~bus_done_type;
		if (!rst_n) begin
			pend.delete();
			bus_ready = 1'b0;
		end else begin
			if (acc) begin
				pend.push_back(ty);
			end
			if (pend.size() > 0 && ($urandom % 4) < (slow ? 1 : 3)) begin
				i = $urandom % pend.size();
				bus_done = 1'b1;
				bus_done_type = pend[i];
				pend.delete(i);
			end
			bus_ready = slow ? (($urandom % 4) == 0) : 1'b1;
		end
		busy_cls = 4'h0;
		foreach (pend[k]) begin
			busy_cls[pend[k]] = 1'b1;
		end
	end
endmodule
`default_nettype wire

//--- dv/mrau_unit_test.sv
// Self-checking testbench of the region attribute unit with a random memory partner.
`default_nettype none
module mrau_unit_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk, rst_n, req_valid, req_write, req_fetch, req_shareable, bar_valid, slow;
	logic [31:0] req_addr;
	logic [1:0] req_size, bar_kind, bus_done_type, bus_type_reg, bus_size_reg;
	logic req_ack_reg, req_fault_reg, bar_ack_reg, exec_hold_reg, refetch_reg, bus_valid_reg;
	logic bus_ready, bus_write_reg, bus_fetch_reg, bus_buf_reg, bus_core_reg, bus_done;
	logic fault_exception_reg;
	logic signed [2:0] fault_prio_reg;
	logic [31:0] bus_addr_reg;
	logic [3:0] busy_cls;  // Classes the partner still has outstanding.
	int n_fail = 0;
	int check_count = 0;
	int cycles = 0;
	// Boundary addresses of every region, walked with fetch off and on.
	logic [31:0] edges [16] = '{32'h0, 32'h1fff_ffff, 32'h2000_0000, 32'h3fff_ffff,
		32'h4000_0000, 32'h5fff_ffff, 32'h6000_0000, 32'h9fff_ffff, 32'ha000_0000,
		32'hdfff_ffff, 32'he000_0000, 32'he000_e000, 32'he000_efff, 32'he00f_ffff,
		32'he010_0000, 32'hffff_ffff};
	mrau_unit #(.CNT_W(4)) mrau_unit_i (.clk(clk), .rst_n(rst_n), .req_valid(req_valid),
		.req_addr(req_addr), .req_write(req_write), .req_size(req_size), .req_fetch(req_fetch),
		.req_shareable(req_shareable), .req_ack_reg(req_ack_reg), .req_fault_reg(req_fault_reg),
		.bar_valid(bar_valid), .bar_kind(bar_kind), .bar_ack_reg(bar_ack_reg),
		.exec_hold_reg(exec_hold_reg), .refetch_reg(refetch_reg), .bus_valid_reg(bus_valid_reg),
		.bus_ready(bus_ready), .bus_addr_reg(bus_addr_reg), .bus_write_reg(bus_write_reg),
		.bus_size_reg(bus_size_reg), .bus_fetch_reg(bus_fetch_reg), .bus_type_reg(bus_type_reg),
		.bus_buf_reg(bus_buf_reg), .bus_core_reg(bus_core_reg), .bus_done(bus_done),
		.bus_done_type(bus_done_type), .fault_exception_reg(fault_exception_reg),
		.fault_prio_reg(fault_prio_reg));
	mrau_mem_model mrau_mem_model_i (.clk(clk), .rst_n(rst_n), .slow(slow),
		.bus_valid_reg(bus_valid_reg), .bus_type_reg(bus_type_reg), .bus_ready(bus_ready),
		.bus_done(bus_done), .bus_done_type(bus_done_type), .busy_cls(busy_cls));
	// Core clock of 4 ns.
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// Prints the verdict and stops the run.
	task automatic end_of_test();
		if (n_fail == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// Compares a field value.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t %s got %h want %h", $time, what, got, exp);
		end
	endtask
	// Compares a single flag.
	task automatic chk_b(input logic got, input logic exp, input string what);
		chk({31'h0, got}, {31'h0, exp}, what);
	endtask
	// Expected ordering class of an address.
	function automatic logic [1:0] exp_cls(input logic [31:0] a, input logic sh);
		if (a <= 32'h3fff_ffff || (a >= 32'h6000_0000 && a <= 32'h9fff_ffff)) begin
			return mrau_pkg::MT_NORMAL;
		end else if (a >= 32'he000_0000 && a <= 32'he00f_ffff) begin
			return mrau_pkg::MT_STRONG;
		end
		return sh ? mrau_pkg::MT_DEV_SH : mrau_pkg::MT_DEV_NS;
	endfunction
	// Classes that must be drained before an access of the given class may issue.
	function automatic logic [3:0] block_mask(input logic [1:0] c);
		case (c)
			mrau_pkg::MT_STRONG: return 4'hf;
			mrau_pkg::MT_DEV_NS: return 4'ha;
			mrau_pkg::MT_DEV_SH: return 4'hc;
			default: return 4'h8;
		endcase
	endfunction
	// One access held until acknowledged, then every visible effect compared.
	task automatic acc(input logic [31:0] a, input logic wr, input logic [1:0] sz,
		input logic fe, input logic sh);
		int n;
		logic [1:0] c;
		logic ft;
		c = exp_cls(a, sh);
		ft = (fe && c != mrau_pkg::MT_NORMAL) || (c == mrau_pkg::MT_STRONG && sz != 2'h2);
		req_valid = 1'b1;
		req_addr = a;
		req_write = wr;
		req_size = sz;
		req_fetch = fe;
		req_shareable = sh;
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (req_ack_reg !== 1'b1 && n < 300);
		req_valid = 1'b0;
		chk_b(req_ack_reg, 1'b1, "access ack");
		chk_b(req_fault_reg, ft, "access fault");
		chk_b(fault_exception_reg, ft, "fault raised");
		chk_b(bus_valid_reg, !ft, "bus offer");
		if (!ft) begin
			chk(bus_type_reg, c, "class");
			chk(busy_cls & block_mask(c), 0, "order");
			chk_b(bus_buf_reg, wr && c != mrau_pkg::MT_STRONG, "buffer");
			chk_b(bus_core_reg, a >= 32'he000_e000 && a <= 32'he000_efff, "core");
			chk(bus_addr_reg, a, "address");
			chk_b(bus_write_reg, wr, "write");
			chk({30'h0, bus_size_reg}, {30'h0, sz}, "size");
			chk_b(bus_fetch_reg, fe, "fetch");
		end
		@(posedge clk);
		#1;
	endtask
	// One barrier held until acknowledged, then drain and side effects compared.
	task automatic bar(input logic [1:0] k);
		int n;
		logic held;
		bar_valid = 1'b1;
		bar_kind = k;
		n = 0;
		held = 1'b0;
		do begin
			@(posedge clk);
			#1;
			n++;
			if (exec_hold_reg === 1'b1) begin
				held = 1'b1;
			end
		end while (bar_ack_reg !== 1'b1 && n < 300);
		bar_valid = 1'b0;
		chk_b(bar_ack_reg, 1'b1, "barrier ack");
		chk(busy_cls, 0, "drained");
		chk_b(bus_valid_reg, 1'b0, "no offer");
		chk_b(held, k == mrau_pkg::BAR_DATA_SYNC, "hold");
		chk_b(exec_hold_reg, 1'b0, "hold end");
		chk_b(refetch_reg, k == mrau_pkg::BAR_INSTR_SYNC, "refetch");
		@(posedge clk);
		#1;
	endtask
	// Cuts a hang short.
	always @(posedge clk) begin
		cycles++;
		if (cycles >= 40000) begin
			n_fail++;
			end_of_test();
		end
	end
	// Reset, boundary walk, word-only checks, then random traffic with barriers.
	initial begin : main
		logic [31:0] a;
		{req_valid, req_write, req_fetch, req_shareable, bar_valid, slow} = 6'h0;
		req_addr = 32'h0;
		req_size = 2'h2;
		bar_kind = 2'h0;
		rst_n = 1'b0;
		void'($urandom(32'h4014));
		repeat (10) @(posedge clk);
		#1;
		rst_n = 1'b1;
		chk(fault_prio_reg, 32'(mrau_pkg::FAULT_PRIO), "priority");
		chk({bus_valid_reg, bus_size_reg, bus_type_reg}, 5'h08, "reset");
		foreach (edges[i]) begin
			acc(edges[i], 1'b0, 2'h2, 1'b0, 1'($urandom));
			acc(edges[i], 1'b1, 2'h2, 1'b1, 1'($urandom));
		end
		for (int s = 0; s < 2; s++) begin
			acc(32'he000_0004, 1'b1, 2'(s), 1'b0, 1'b0);
		end
		for (int k = 0; k < 3; k++) begin
			bar(2'(k));
		end
		for (int j = 0; j < 600; j++) begin
			slow = (j / 100) % 2 == 1;
			a = $urandom;
			if (($urandom % 4) == 0) begin
				a = 32'he000_0000 | ($urandom & 32'h000f_fffc);
			end
			acc(a, 1'($urandom), 2'($urandom % 3), ($urandom % 4) == 0, 1'($urandom));
			if (($urandom % 8) == 0) begin
				bar(2'($urandom % 3));
			end
		end
		end_of_test();
	end
endmodule
`default_nettype wire
